// ===== rtl/lsld_pkg.sv
/*
 * Package for the LED shift/latch driver: widths, counts, reset values, structs.
 * Assumes a 25 MHz core clock and a serial link clock of its own.
 */
`default_nettype none
package lsld_pkg;
    localparam int unsigned WORD_W           = 16;
    localparam int unsigned FIFO_DEPTH       = 16;
    localparam int unsigned CORE_PERIOD_NS   = 40;
    localparam int unsigned CHAIN_DELAY_CYC  = 16;
    localparam logic [15:0] SHIFT_RESET      = 16'h0000;
    localparam logic [15:0] LATCH_RESET      = 16'h0000;
    localparam logic [15:0] SINK_ALL_OFF     = 16'h0000;
    localparam logic [3:0]  CNT_RESET        = 4'h0;
    localparam logic [3:0]  CNT_LAST         = 4'hF;
    // snapshot of the link side passed to the core
    typedef struct packed {
        logic [15:0] shift_word;
    } lsld_word_t;
    // state of the output stage
    typedef enum logic [1:0] {
        LSLD_HOLD   = 2'b00,
        LSLD_TRANSP = 2'b01,
        LSLD_HOT    = 2'b11
    } lsld_state_t;
endpackage
`default_nettype wire

// ===== rtl/lsld_fifo.sv
/*
 * Small synchronous FIFO, flip-flop storage, valid/ready on both sides.
 * Assumes a single clock and an active-low reset already synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
module lsld_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt_reg == (AW+1)'(DEPTH)) |-> !push)
        else $error("fifo pushed while full");
endmodule
`default_nettype wire

// ===== rtl/lsld_shift.sv
/*
 * Link-side 16-bit shift register on the serial clock, with chain output.
 * Assumes the serial clock comes from the controller; no reset on the link side.
 */
`timescale 1ns/1ns
`default_nettype none
module lsld_shift (
    // link
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    output logic             serial_out,
    // parallel view and word toggle
    output logic [15:0]      shift_reg,
    output logic             word_tgl_reg
);
    // link side has no reset; simulation starts from cleared stages
    logic [15:0] stage_reg   = lsld_pkg::SHIFT_RESET;
    logic [15:0] word_reg    = lsld_pkg::SHIFT_RESET;
    logic [3:0]  bit_cnt_reg = lsld_pkg::CNT_RESET;
    logic        tgl_reg     = 1'b0;

    always_ff @(posedge serial_clk) begin
        stage_reg <= {stage_reg[14:0], serial_in};
    end

    assign serial_out = stage_reg[15];

    // completed word held for sixteen edges, toggle tells the core
    always_ff @(posedge serial_clk) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == lsld_pkg::CNT_LAST) begin
            word_reg <= {stage_reg[14:0], serial_in};
            tgl_reg  <= ~tgl_reg;
        end
    end

    assign shift_reg    = word_reg;
    assign word_tgl_reg = tgl_reg;

    a_chain_delay: assert property (@(posedge serial_clk)
        ##16 (serial_out == $past(serial_in, 16)))
        else $error("serial_out not sixteen edges behind serial_in");
    a_shift_lsb: assert property (@(posedge serial_clk)
        ##1 (stage_reg[0] == $past(serial_in)))
        else $error("lowest stage did not take serial_in");
endmodule
`default_nettype wire

// ===== rtl/lsld_top.sv
/*
 * LED shift/latch driver core: serial shift register, transparent load latch,
 * blanking, thermal cutoff and open-drain sink outputs.
 * SERIAL_OUT is the last shift stage, sixteen link edges behind SERIAL_IN.
 * Assumes SERIAL_CLK is a separate link clock; LATCH_LOAD, BLANK_N, and the
 * thermal flags are asynchronous pins sampled on CORE_CLK.
 */
// How it works
// - a device word is exactly sixteen bits, as deep as shift register and latch
// - serial_in is sampled on each rising serial clock edge
// - each rising edge shifts by one, serial_in into the lowest stage
// - latch follows the shift register while latch_load is high
// - latch captures on latch_load falling and holds while low
// - blank high puts every sink output in high impedance, latch untouched
// - blank low makes each sink output follow its latch bit, except during thermal cutoff
// - shifting and latching ignore the blanking input entirely
// - serial_out is the last stage, sixteen edges behind serial_in
// - over-temperature forces sinks off until the low threshold is crossed
// - thermal cutoff leaves shift register and latch intact
`timescale 1ns/1ns
`default_nettype none
module lsld_top (
    // core clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // serial link
    input  wire logic        SERIAL_CLK,
    input  wire logic        SERIAL_IN,
    output logic             SERIAL_OUT,
    // load and blank
    input  wire logic        LATCH_LOAD,
    input  wire logic        OUTPUT_BLANK_N,
    // thermal monitor comparators
    input  wire logic        TEMP_ABOVE_HIGH,
    input  wire logic        TEMP_BELOW_LOW,
    // sink outputs, open drain: pin is pulled low where enable is high
    output logic [15:0]      LED_SINK_OUTPUTS_O,
    output logic [15:0]      LED_SINK_OUTPUTS_OE,
    // status
    output logic             THERMAL_CUTOFF,
    output logic [15:0]      LATCH_VIEW,
    output logic             WORD_OVERRUN
);
    logic [1:0]  rst_sync_reg;
    logic        rst_n_int;
    logic [15:0] shift_word;
    logic        word_tgl;
    logic        link_out;
    logic [2:0]  tgl_sync_reg;
    logic [15:0] snap_reg;
    logic        snap_valid_reg;
    logic [1:0]  le_sync_reg;
    logic [1:0]  bl_sync_reg;
    logic [1:0]  hi_sync_reg;
    logic [1:0]  lo_sync_reg;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic [15:0] cur_word_reg;
    logic [15:0] latch_reg;
    logic        le_d_reg;
    lsld_pkg::lsld_state_t state_reg;
    lsld_pkg::lsld_word_t  word_s;
    logic        sink_en;
    logic        word_seen;

    // cutoff state decode, shared by gating, flag and checks
    function automatic logic is_hot(input lsld_pkg::lsld_state_t s);
        return s == lsld_pkg::LSLD_HOT;
    endfunction

    // reset release
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_reg[1];

    lsld_shift u_shift (
        .serial_clk   (SERIAL_CLK),
        .serial_in    (SERIAL_IN),
        .serial_out   (link_out),
        .shift_reg    (shift_word),
        .word_tgl_reg (word_tgl)
    );

    // chain output is the last stage flip-flop itself, no extra delay
    assign SERIAL_OUT = link_out;

    // link word toggle into the core domain
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            tgl_sync_reg <= 3'h0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], word_tgl};
        end
    end
    assign word_seen = tgl_sync_reg[2] ^ tgl_sync_reg[1];

    // pin synchronisers
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            le_sync_reg  <= 2'h0;
            bl_sync_reg  <= 2'h3;
            hi_sync_reg  <= 2'h0;
            lo_sync_reg  <= 2'h0;
        end else begin
            le_sync_reg  <= {le_sync_reg[0], LATCH_LOAD};
            bl_sync_reg  <= {bl_sync_reg[0], OUTPUT_BLANK_N};
            hi_sync_reg  <= {hi_sync_reg[0], TEMP_ABOVE_HIGH};
            lo_sync_reg  <= {lo_sync_reg[0], TEMP_BELOW_LOW};
        end
    end

    // word capture: the held word stands for sixteen link edges after
    // the toggle, far longer than the three-flop crossing needs
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            snap_reg       <= lsld_pkg::SHIFT_RESET;
            snap_valid_reg <= 1'b0;
        end else begin
            snap_valid_reg <= word_seen;
            if (word_seen) begin
                snap_reg <= shift_word;
            end
        end
    end

    assign word_s.shift_word = snap_reg;

    lsld_fifo #(
        .WIDTH (lsld_pkg::WORD_W),
        .DEPTH (lsld_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst_n     (rst_n_int),
        .in_valid  (snap_valid_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (word_s.shift_word),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    // newest completed word is the shift register image the latch sees
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            cur_word_reg <= lsld_pkg::SHIFT_RESET;
        end else if (fifo_out_valid) begin
            cur_word_reg <= fifo_out_data;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            WORD_OVERRUN <= 1'b0;
        end else if (snap_valid_reg && !fifo_in_ready) begin
            WORD_OVERRUN <= 1'b1;
        end
    end

    // load latch, independent of blanking and temperature
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            latch_reg <= lsld_pkg::LATCH_RESET;
            le_d_reg  <= 1'b0;
        end else begin
            le_d_reg <= le_sync_reg[1];
            if (le_sync_reg[1]) begin
                latch_reg <= cur_word_reg;
            end
        end
    end
    // falling edge: latch_reg keeps the value taken while high

    // output state, thermal hysteresis
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_reg <= lsld_pkg::LSLD_HOLD;
        end else begin
            case (state_reg)
                lsld_pkg::LSLD_HOLD: begin
                    if (hi_sync_reg[1]) begin
                        state_reg <= lsld_pkg::LSLD_HOT;
                    end else if (le_sync_reg[1]) begin
                        state_reg <= lsld_pkg::LSLD_TRANSP;
                    end
                end
                lsld_pkg::LSLD_TRANSP: begin
                    if (hi_sync_reg[1]) begin
                        state_reg <= lsld_pkg::LSLD_HOT;
                    end else if (!le_sync_reg[1]) begin
                        state_reg <= lsld_pkg::LSLD_HOLD;
                    end
                end
                lsld_pkg::LSLD_HOT: begin
                    if (lo_sync_reg[1] && !hi_sync_reg[1]) begin
                        state_reg <= lsld_pkg::LSLD_HOLD;
                    end
                end
                default: begin
                    state_reg <= lsld_pkg::LSLD_HOLD;
                end
            endcase
        end
    end

    assign sink_en = bl_sync_reg[1] == 1'b0 && !is_hot(state_reg);

    // sink drivers from flip-flops; latch is never cleared by gating
    always_ff @(posedge CORE_CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            LED_SINK_OUTPUTS_OE <= lsld_pkg::SINK_ALL_OFF;
            LED_SINK_OUTPUTS_O  <= lsld_pkg::SINK_ALL_OFF;
            THERMAL_CUTOFF      <= 1'b0;
            LATCH_VIEW          <= lsld_pkg::LATCH_RESET;
        end else begin
            LED_SINK_OUTPUTS_O <= lsld_pkg::SINK_ALL_OFF;
            if (sink_en) begin
                LED_SINK_OUTPUTS_OE <= latch_reg;
            end else begin
                LED_SINK_OUTPUTS_OE <= lsld_pkg::SINK_ALL_OFF;
            end
            THERMAL_CUTOFF <= is_hot(state_reg);
            LATCH_VIEW     <= latch_reg;
        end
    end

    // checks: latch
    a_hold_low: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        !le_sync_reg[1] |=> $stable(latch_reg))
        else $error("latch changed while load low");
    a_fall_capture: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        (le_d_reg && !le_sync_reg[1]) |-> latch_reg == $past(cur_word_reg))
        else $error("latch missed the word at load fall");
    a_transp_copy: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        le_sync_reg[1] |=> latch_reg == $past(cur_word_reg))
        else $error("latch not transparent while load high");
    a_blank_load: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        (bl_sync_reg[1] && le_sync_reg[1]) |=> latch_reg == $past(cur_word_reg))
        else $error("load ignored while blanked");
    a_thermal_keep: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        (is_hot(state_reg) && !le_sync_reg[1]) |=> $stable(latch_reg))
        else $error("thermal cutoff disturbed latch");

    // checks: blanking and sinks
    a_blank_off: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        bl_sync_reg[1] |=> LED_SINK_OUTPUTS_OE == '0)
        else $error("sink driven while blanked");
    a_blank_keep: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        (bl_sync_reg[1] && !le_sync_reg[1]) |=> $stable(latch_reg))
        else $error("blanking disturbed latch");
    a_follow_latch: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        sink_en |=> LED_SINK_OUTPUTS_OE == $past(latch_reg))
        else $error("sink does not follow latch");
    a_sink_lit_only: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        sink_en |=> (LED_SINK_OUTPUTS_OE & ~$past(latch_reg)) == '0)
        else $error("sink on for a cleared latch bit");
    a_sink_level: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        LED_SINK_OUTPUTS_O == '0)
        else $error("sink output level not low");

    // checks: thermal
    a_hot_off: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        is_hot(state_reg) |=> LED_SINK_OUTPUTS_OE == '0)
        else $error("sink driven during thermal cutoff");
    a_hot_entry: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        hi_sync_reg[1] |=> is_hot(state_reg))
        else $error("cutoff not entered");
    a_hot_hold: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        (is_hot(state_reg) && !lo_sync_reg[1]) |=> is_hot(state_reg))
        else $error("cutoff left above the low threshold");
    a_hot_exit: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        (is_hot(state_reg) && lo_sync_reg[1] && !hi_sync_reg[1]) |=> !is_hot(state_reg))
        else $error("cutoff not left below the low threshold");
    a_cutoff_flag: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        is_hot(state_reg) |=> THERMAL_CUTOFF)
        else $error("cutoff flag not raised");

    // checks: word path
    a_word_snap: assert property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        word_seen |=> snap_valid_reg && snap_reg == $past(shift_word))
        else $error("completed word not captured");

    c_load_pulse: cover property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        le_sync_reg[1] ##1 !le_sync_reg[1]);
    c_blank_load: cover property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        bl_sync_reg[1] && le_sync_reg[1]);
    c_hot_cycle: cover property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        state_reg == lsld_pkg::LSLD_HOT ##1 state_reg == lsld_pkg::LSLD_HOLD);
    c_word_in: cover property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        snap_valid_reg && fifo_in_ready);
    c_lit: cover property (@(posedge CORE_CLK) disable iff (!rst_n_int)
        LED_SINK_OUTPUTS_OE != '0);
endmodule
`default_nettype wire

// ===== testbench/lsld_ctrl_model.sv
/*
 * Controller model: drives the serial link of the LED shift/latch driver.
 * Assumes a 32 ns link clock that runs only within frames and idles low.
 */
`timescale 1ns/1ns
`default_nettype none
module lsld_ctrl_model (
    // link toward the device
    output logic        serial_clk,
    output logic        serial_in,
    input  wire logic   serial_out,
    // chain output as the next device in the chain samples it
    output logic [15:0] dout_hist
);
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b1;
        dout_hist = 16'h0000;
    end

    // one 16-bit frame, data moves while the clock is low
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            serial_in = w[i];
            // next device takes the chain output at this rising edge
            #16 dout_hist = {dout_hist[14:0], serial_out};
            serial_clk = 1'b1;
            #16 serial_clk = 1'b0;
        end
        // released line shows the inverse of the last bit
        serial_in = ~w[0];
    endtask
endmodule
`default_nettype wire

// ===== testbench/lsld_top_test.sv
/*
 * Self-checking bench for the LED shift/latch driver top.
 * Assumes the controller model drives the link; core inputs driven here.
 */
`timescale 1ns/1ns
`default_nettype none
module lsld_top_test;
    logic        core_clk;
    logic        rst_n;
    logic        latch_load;
    logic        blank_n;
    logic        temp_hi;
    logic        temp_lo;
    logic        serial_clk;
    logic        serial_in;
    logic        serial_out;
    logic [15:0] dout_hist;
    logic [15:0] sink_o;
    logic [15:0] sink_oe;
    logic [15:0] latch_view;
    logic        cutoff;
    logic        overrun;
    int          fail_count;
    int          compares;

    lsld_top i_lsld_top (
        .CORE_CLK            (core_clk),
        .RST_N               (rst_n),
        .SERIAL_CLK          (serial_clk),
        .SERIAL_IN           (serial_in),
        .SERIAL_OUT          (serial_out),
        .LATCH_LOAD          (latch_load),
        .OUTPUT_BLANK_N      (blank_n),
        .TEMP_ABOVE_HIGH     (temp_hi),
        .TEMP_BELOW_LOW      (temp_lo),
        .LED_SINK_OUTPUTS_O  (sink_o),
        .LED_SINK_OUTPUTS_OE (sink_oe),
        .THERMAL_CUTOFF      (cutoff),
        .LATCH_VIEW          (latch_view),
        .WORD_OVERRUN        (overrun)
    );

    lsld_ctrl_model i_lsld_ctrl_model (
        .serial_clk (serial_clk),
        .serial_in  (serial_in),
        .serial_out (serial_out),
        .dout_hist  (dout_hist)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // link traffic starts off the core edge
    task automatic send(input logic [15:0] w);
        #7 i_lsld_ctrl_model.send_word(w);
        cyc(1);
    endtask

    task automatic load_pulse();
        latch_load <= 1'b1;
        cyc(4);
        latch_load <= 1'b0;
        cyc(8);
    endtask

    task automatic wait_view(input logic [15:0] exp);
        int n;
        n = 0;
        while (latch_view !== exp && n < 40) begin
            cyc(1);
            n++;
        end
        if (latch_view !== exp) begin
            fail_count++;
            $display("BAD latch_view wait expected %h seen %h", exp, latch_view);
            conclude();
        end
    endtask

    task automatic t_load();
        send(16'hA5C3);
        cyc(10);
        check("view before load", latch_view, 16'h0000);
        load_pulse();
        check("view after load", latch_view, 16'hA5C3);
        check("sink enables", sink_oe, 16'hA5C3);
        check("sink levels", sink_o, 16'h0000);
        $display("done: load");
    endtask

    task automatic t_blank();
        send(16'h3C5A);
        cyc(10);
        check("view held", latch_view, 16'hA5C3);
        blank_n <= 1'b1;
        cyc(6);
        check("blanked enables", sink_oe, 16'h0000);
        check("view under blank", latch_view, 16'hA5C3);
        load_pulse();
        check("load under blank", latch_view, 16'h3C5A);
        check("still blanked", sink_oe, 16'h0000);
        blank_n <= 1'b0;
        cyc(6);
        check("unblanked enables", sink_oe, 16'h3C5A);
        $display("done: blank");
    endtask

    task automatic t_transp();
        latch_load <= 1'b1;
        send(16'h8001);
        wait_view(16'h8001);
        send(16'h7FFE);
        wait_view(16'h7FFE);
        latch_load <= 1'b0;
        cyc(6);
        send(16'h1234);
        cyc(10);
        check("view after fall", latch_view, 16'h7FFE);
        check("enables after fall", sink_oe, 16'h7FFE);
        $display("done: transparent");
    endtask

    task automatic t_chain();
        send(16'hF00D);
        send(16'h0FF0);
        check("chain output", dout_hist, 16'hF00D);
        load_pulse();
        check("chain load", latch_view, 16'h0FF0);
        $display("done: chain");
    endtask

    task automatic t_thermal();
        temp_hi <= 1'b1;
        cyc(6);
        check("cutoff on", {15'h0000, cutoff}, 16'h0001);
        check("hot enables", sink_oe, 16'h0000);
        check("hot view", latch_view, 16'h0FF0);
        temp_hi <= 1'b0;
        cyc(6);
        check("cutoff held", {15'h0000, cutoff}, 16'h0001);
        temp_lo <= 1'b1;
        cyc(6);
        check("cutoff off", {15'h0000, cutoff}, 16'h0000);
        check("resumed enables", sink_oe, 16'h0FF0);
        temp_lo <= 1'b0;
        check("no overrun", {15'h0000, overrun}, 16'h0000);
        $display("done: thermal");
    endtask

    initial begin
        fail_count = 0;
        compares = 0;
        rst_n = 1'b0;
        latch_load = 1'b0;
        blank_n = 1'b0;
        temp_hi = 1'b0;
        temp_lo = 1'b0;
        cyc(6);
        check("reset enables", sink_oe, 16'h0000);
        check("reset view", latch_view, 16'h0000);
        cyc(2);
        rst_n <= 1'b1;
        cyc(8);
        $display("done: reset");
        t_load();
        t_blank();
        t_transp();
        t_chain();
        t_thermal();
        conclude();
    end
endmodule
`default_nettype wire
